// [core/pca_core.sv]
/*
 * programmable counter array: shared 16-bit time base and five
 * compare/capture modules with capture, timer, toggle, pwm and watchdog.
 * assumes asynchronous pin inputs, synchronised here, a 40 MHz clock and an avalon-mm master.
 */
`timescale 1ns/100ps

// Summary of operation
// - counter advances on clk/6, clk/2, timer 0 overflow or external pin.
// - select 00 clk/6, 01 clk/2, 10 timer0, 11 external pin.
// - one 16-bit counter, high and low bytes, times all five modules.
// - idle stop bit set halts counter while cpu idles.
// - counter runs only while run control bit is set.
// - overflow flag set on rollover; only a software write clears it.
// - module event flag set on match or capture; software may clear.
// - all five module events and overflow share one interrupt line.
// - module interrupt enable gates its event flag onto the interrupt.
// - unused pins stay ordinary port I/O.
// - falling, rising or both edge enables arm capture on module input.
// - valid edge copies counter into module value pair, sets event flag.
// - comparator and hit enables set flag when counter equals value.
// - hit flag enable sets event flag on every equality.
// - invert, hit and comparator enables toggle output on each match.
// - pwm output low while counter low below compare low, else high.
// - in pwm, compare low reloads from compare high at low byte wrap.
// - all pwm outputs share one frequency, duty set per module.
// - module 4 watchdog: enable set and match issues internal reset.
// - watchdog reset never drives external reset pin.
// - module 4 keeps ordinary modes while watchdog disabled.
module pca_core
   import pca_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // register bus
   input  wire pca_pkg::av_req_t     av_req,
   output pca_pkg::av_rsp_t          av_rsp,
   // count sources
   input  wire logic                 timer0_overflow,
   input  wire logic                 external_count_input,
   // module pins
   input  wire logic [4:0]           module_io_pin_in,
   output logic      [4:0]           module_io_pin_out,
   output logic      [4:0]           module_io_pin_oe,
   // system
   output logic                      irq,
   output logic                      watchdog_reset
);
   import pca_pkg::*;

   logic [7:0]  counter_mode_register;
   logic        run_control_bit;
   logic        overflow_flag;
   logic [4:0]  module_event_flag;
   logic [7:0]  module_mode_register [NUM_MOD];
   logic [7:0]  module_value_low     [NUM_MOD];
   logic [7:0]  module_value_high    [NUM_MOD];
   logic [7:0]  counter_low_byte;
   logic [7:0]  counter_high_byte;
   logic        cpu_idle;
   logic [2:0]  prescale;
   logic [1:0]  ext_sync;
   logic        ext_prev;
   logic [9:0]  cap_sync;
   logic [4:0]  cap_prev;
   logic [4:0]  pin_level;
   logic        tick;
   logic [15:0] next_count;
   logic        wr_hit;
   logic        rd_hit;
   logic [31:0] next_readdata;
   logic [4:0]  hit;
   logic [4:0]  hit_prev;
   logic [4:0]  capture;
   logic        low_wrap;
   logic [7:0]  wdata;

   // register address within a module group
   function automatic logic in_group(input logic [7:0] a,
                                     input logic [7:0] base);
      in_group = (a >= base) &&
                 (a < base + 8'(NUM_MOD * 4));
   endfunction

   function automatic int unsigned mod_idx(input logic [7:0] a);
      mod_idx = int'(a[4:2]);
   endfunction

   assign wdata  = av_req.writedata[7:0];
   assign wr_hit = av_req.write && av_req.byteenable[0];
   assign rd_hit = av_req.read;

   // single-cycle answer, never stalled
   assign av_rsp.waitrequest = 1'b0;

   // input synchronisers and edge history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_sync <= 2'h0;
         ext_prev <= 1'b0;
         cap_sync <= 10'h000;
         cap_prev <= 5'h00;
      end else begin
         ext_sync <= {ext_sync[0], external_count_input};
         ext_prev <= ext_sync[1];
         cap_sync <= {cap_sync[4:0], module_io_pin_in};
         cap_prev <= cap_sync[9:5];
      end
   end
   assign pin_level = cap_sync[9:5];

   // clk/6 prescaler
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= 3'h0;
      end else if (prescale == DIV6_LAST) begin
         prescale <= 3'h0;
      end else begin
         prescale <= prescale + 3'h1;
      end
   end

   // count source selection and gating
   always_comb begin
      tick = 1'b0;
      case (src_t'({counter_mode_register[B_SRC_HI],
                    counter_mode_register[B_SRC_LO]}))
         SRC_DIV6: tick = (prescale == DIV6_LAST);
         SRC_DIV2: tick = prescale[0];
         SRC_T0:   tick = timer0_overflow;
         SRC_EXT:  tick = ext_sync[1] && !ext_prev;
         default:  tick = 1'b0;
      endcase
      if (!run_control_bit) begin
         tick = 1'b0;
      end
      if (cpu_idle && counter_mode_register[B_IDLE_STOP]) begin
         tick = 1'b0;
      end
   end

   assign next_count = {counter_high_byte, counter_low_byte} + 16'h0001;
   assign low_wrap   = tick && (counter_low_byte == BYTE_FF);

   // shared time base, software may load either byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_low_byte  <= BYTE_ZERO;
         counter_high_byte <= BYTE_ZERO;
      end else if (wr_hit && av_req.address == OFS_COUNT_L) begin
         counter_low_byte <= wdata;
      end else if (wr_hit && av_req.address == OFS_COUNT_H) begin
         counter_high_byte <= wdata;
      end else if (tick) begin
         counter_low_byte  <= next_count[7:0];
         counter_high_byte <= next_count[15:8];
      end
   end

   // mode, run and idle registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_mode_register <= BYTE_ZERO;
         run_control_bit       <= 1'b0;
         cpu_idle              <= 1'b0;
      end else if (wr_hit) begin
         if (av_req.address == OFS_MODE) begin
            counter_mode_register <= wdata & MODE_MASK;
         end else if (av_req.address == OFS_CONTROL) begin
            run_control_bit <= wdata[B_RUN];
         end else if (av_req.address == OFS_IDLE) begin
            cpu_idle <= wdata[0];
         end
      end
   end

   // per-module match and capture detection
   always_comb begin
      for (int n = 0; n < NUM_MOD; n++) begin
         hit[n] = module_mode_register[n][B_COMP_EN] &&
                  {counter_high_byte, counter_low_byte} ==
                  {module_value_high[n], module_value_low[n]};
         capture[n] =
            (module_mode_register[n][B_CAP_RISE] &&
             pin_level[n] && !cap_prev[n]) ||
            (module_mode_register[n][B_CAP_FALL] &&
             !pin_level[n] && cap_prev[n]);
      end
   end

   // overflow and event flags; hardware set wins over software clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag     <= 1'b0;
         module_event_flag <= 5'h00;
      end else begin
         if (wr_hit && av_req.address == OFS_CONTROL) begin
            overflow_flag     <= wdata[B_OVF_FLAG];
            module_event_flag <= wdata[4:0];
         end
         if (tick && next_count == 16'h0000) begin
            overflow_flag <= 1'b1;
         end
         for (int n = 0; n < NUM_MOD; n++) begin
            if (capture[n] ||
                (hit[n] && module_mode_register[n][B_HIT_FLAG])) begin
               module_event_flag[n] <= 1'b1;
            end
         end
      end
   end

   // module mode and value registers, capture and pwm reload
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int n = 0; n < NUM_MOD; n++) begin
            module_mode_register[n] <= BYTE_ZERO;
            module_value_low[n]     <= BYTE_ZERO;
            module_value_high[n]    <= BYTE_ZERO;
         end
      end else begin
         for (int n = 0; n < NUM_MOD; n++) begin
            if (capture[n]) begin
               module_value_low[n]  <= counter_low_byte;
               module_value_high[n] <= counter_high_byte;
            end else if (low_wrap && module_mode_register[n][B_PWM] &&
                         module_mode_register[n][B_COMP_EN]) begin
               module_value_low[n] <= module_value_high[n];
            end
         end
         if (wr_hit) begin
            if (in_group(av_req.address, OFS_MMODE)) begin
               module_mode_register[mod_idx(av_req.address)] <=
                  wdata & MMODE_MASK;
            end else if (in_group(av_req.address, OFS_VAL_L)) begin
               module_value_low[mod_idx(av_req.address)] <= wdata;
            end else if (in_group(av_req.address, OFS_VAL_H)) begin
               module_value_high[mod_idx(av_req.address)] <= wdata;
            end
         end
      end
   end

   // pin outputs: toggle once per new match, or pwm compare on low byte
   // a match can stand for many cycles at slow count rates
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         module_io_pin_out <= 5'h00;
         hit_prev          <= 5'h00;
      end else begin
         hit_prev <= hit;
         for (int n = 0; n < NUM_MOD; n++) begin
            if (module_mode_register[n][B_PWM] &&
                module_mode_register[n][B_COMP_EN]) begin
               module_io_pin_out[n] <=
                  !(counter_low_byte < module_value_low[n]);
            end else if (hit[n] && !hit_prev[n] &&
                         module_mode_register[n][B_INVERT] &&
                         module_mode_register[n][B_HIT_FLAG]) begin
               module_io_pin_out[n] <= !module_io_pin_out[n];
            end
         end
      end
   end

   // drive a pin only in output modes, else it stays port I/O
   always_comb begin
      for (int n = 0; n < NUM_MOD; n++) begin
         module_io_pin_oe[n] = module_mode_register[n][B_COMP_EN] &&
            (module_mode_register[n][B_PWM] ||
             module_mode_register[n][B_INVERT]);
      end
   end

   // shared interrupt request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (overflow_flag && counter_mode_register[B_OVF_IE]) ||
                |(module_event_flag & {
                   module_mode_register[4][B_MOD_IE],
                   module_mode_register[3][B_MOD_IE],
                   module_mode_register[2][B_MOD_IE],
                   module_mode_register[1][B_MOD_IE],
                   module_mode_register[0][B_MOD_IE]});
      end
   end

   // watchdog on module 4; internal reset only, no pin drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_reset <= 1'b0;
      end else begin
         watchdog_reset <= counter_mode_register[B_WDOG_EN] &&
            {counter_high_byte, counter_low_byte} ==
            {module_value_high[WD_MOD], module_value_low[WD_MOD]};
      end
   end

   // read data mux
   always_comb begin
      next_readdata = READ_ZERO;
      if (av_req.address == OFS_MODE) begin
         next_readdata[7:0] = counter_mode_register;
      end else if (av_req.address == OFS_CONTROL) begin
         next_readdata[7:0] = {overflow_flag, run_control_bit, 1'b0,
                               module_event_flag};
      end else if (av_req.address == OFS_COUNT_L) begin
         next_readdata[7:0] = counter_low_byte;
      end else if (av_req.address == OFS_COUNT_H) begin
         next_readdata[7:0] = counter_high_byte;
      end else if (av_req.address == OFS_IDLE) begin
         next_readdata[0] = cpu_idle;
      end else if (in_group(av_req.address, OFS_MMODE)) begin
         next_readdata[7:0] = module_mode_register[mod_idx(av_req.address)];
      end else if (in_group(av_req.address, OFS_VAL_L)) begin
         next_readdata[7:0] = module_value_low[mod_idx(av_req.address)];
      end else if (in_group(av_req.address, OFS_VAL_H)) begin
         next_readdata[7:0] = module_value_high[mod_idx(av_req.address)];
      end
   end

   // read data presented combinationally in the accepted cycle
   assign av_rsp.readdata = rd_hit ? next_readdata : READ_ZERO;

endmodule

// [include/pca_pkg.sv]
/*
 * package for the counter array: register offsets, field positions,
 * reset values, count source encodings and bus carrier structs.
 * assumes a 32-bit avalon-mm slave with word addressing by byte address.
 */
package pca_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_MODE    = 8'h00; // counter_mode_register
   localparam logic [7:0] OFS_CONTROL = 8'h04; // counter_control_register
   localparam logic [7:0] OFS_COUNT_L = 8'h08; // counter_low_byte
   localparam logic [7:0] OFS_COUNT_H = 8'h0C; // counter_high_byte
   localparam logic [7:0] OFS_IDLE    = 8'h10; // cpu idle indication
   localparam logic [7:0] OFS_MMODE   = 8'h20; // module_mode_register n
   localparam logic [7:0] OFS_VAL_L   = 8'h40; // module_value_low n
   localparam logic [7:0] OFS_VAL_H   = 8'h60; // module_value_high n
   localparam logic [7:0] OFS_STRIDE  = 8'h04;

   localparam int NUM_MOD = 5;
   localparam int WD_MOD  = 4;

   // counter_mode_register bits
   localparam int B_IDLE_STOP = 7;
   localparam int B_WDOG_EN   = 6;
   localparam int B_SRC_HI    = 2;
   localparam int B_SRC_LO    = 1;
   localparam int B_OVF_IE    = 0;
   localparam logic [7:0] MODE_MASK = 8'hC7;

   // counter_control_register bits
   localparam int B_OVF_FLAG = 7;
   localparam int B_RUN      = 6;

   // module_mode_register bits
   localparam int B_COMP_EN  = 6;
   localparam int B_CAP_RISE = 5;
   localparam int B_CAP_FALL = 4;
   localparam int B_HIT_FLAG = 3;
   localparam int B_INVERT   = 2;
   localparam int B_PWM      = 1;
   localparam int B_MOD_IE   = 0;
   localparam logic [7:0] MMODE_MASK = 8'h7F;

   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [7:0]  BYTE_FF   = 8'hFF;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // count source select encodings
   typedef enum logic [1:0] {
      SRC_DIV6 = 2'h0,
      SRC_DIV2 = 2'h1,
      SRC_T0   = 2'h2,
      SRC_EXT  = 2'h3
   } src_t;

   localparam logic [2:0] DIV6_LAST = 3'h5;

   // avalon request carrier
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } av_req_t;

   // avalon answer carrier
   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } av_rsp_t;

endpackage

// [testbench/pca_core_properties.sv]
/* checker for pca_core: bus answers, pin enables, irq and watchdog.
   assumes the pca_pkg register map; bound below. */
`timescale 1ns/100ps
module pca_core_props
   import pca_pkg::*;
(
   // clock and bus
   input wire logic             clk,
   input wire logic             rst_n,
   input wire pca_pkg::av_req_t av_req,
   input wire pca_pkg::av_rsp_t av_rsp,
   // pins and system
   input wire logic             timer0_overflow,
   input wire logic             external_count_input,
   input wire logic [4:0]       module_io_pin_in,
   input wire logic [4:0]       module_io_pin_out,
   input wire logic [4:0]       module_io_pin_oe,
   input wire logic             irq,
   input wire logic             watchdog_reset
);
   logic [7:0] mode;
   logic [7:0] mmode [NUM_MOD];
   logic [4:0] oe_exp;
   logic       ie_any;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow of the mode registers as written over the bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= BYTE_ZERO;
         for (int i = 0; i < NUM_MOD; i++) mmode[i] <= BYTE_ZERO;
      end else if (av_req.write && av_req.byteenable[0]) begin
         if (av_req.address == OFS_MODE)
            mode <= av_req.writedata[7:0] & MODE_MASK;
         for (int i = 0; i < NUM_MOD; i++)
            if (av_req.address == OFS_MMODE + 8'(i * 4))
               mmode[i] <= av_req.writedata[7:0] & MMODE_MASK;
      end
   end
   // expected pin enables and any irq enable
   always_comb begin
      ie_any = mode[B_OVF_IE];
      for (int i = 0; i < NUM_MOD; i++) begin
         oe_exp[i] = mmode[i][B_COMP_EN]
                   & (mmode[i][B_PWM] | mmode[i][B_INVERT]);
         ie_any = ie_any | mmode[i][B_MOD_IE];
      end
   end
   sequence s_rd(a);
      av_req.read && av_req.address == a;
   endsequence
   sequence s_masked;
      !ie_any;
   endsequence
   a_no_wait: assert property (av_rsp.waitrequest == 1'b0)
      else $error("waitrequest raised");
   a_upper_zero: assert property (av_req.read |->
      av_rsp.readdata[31:8] == 24'h000000) else $error("upper bits set");
   a_unmapped_zero: assert property (s_rd(8'h34) |->
      av_rsp.readdata == READ_ZERO) else $error("unmapped read nonzero");
   a_mode_readback: assert property (s_rd(OFS_MODE) |->
      av_rsp.readdata[7:0] == mode) else $error("mode readback wrong");
   a_mmode_readback: assert property (s_rd(OFS_MMODE + 8'h08) |->
      av_rsp.readdata[7:0] == mmode[2]) else $error("module mode wrong");
   a_oe_decode: assert property (module_io_pin_oe == oe_exp)
      else $error("pin enable wrong");
   a_irq_masked: assert property (s_masked |=> !irq)
      else $error("irq while all enables clear");
   a_wdog_gated: assert property (watchdog_reset |->
      $past(mode[B_WDOG_EN])) else $error("watchdog reset while disabled");
endmodule
bind pca_core pca_core_props u_props (.clk(clk), .rst_n(rst_n),
   .av_req(av_req), .av_rsp(av_rsp), .timer0_overflow(timer0_overflow),
   .external_count_input(external_count_input),
   .module_io_pin_in(module_io_pin_in),
   .module_io_pin_out(module_io_pin_out),
   .module_io_pin_oe(module_io_pin_oe), .irq(irq),
   .watchdog_reset(watchdog_reset));

// [testbench/pca_pins.sv]
/* far side: port pins with pull-ups, external count and timer 0
   overflow sources. assumes clk is the array clock. */
`timescale 1ns/100ps
module pca_pins (
   // clock
   input  wire logic       clk,
   // array side
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe,
   // far side
   output logic            t0_ovf,
   output logic            ext_in,
   output logic [4:0]      pin_in
);
   logic [4:0] drive;
   // pad level: array when enabled, else outside driver
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
   initial begin
      t0_ovf = 1'b0;
      ext_in = 1'b0;
      drive = 5'h1F;
   end
   // one-cycle overflow pulses
   task automatic t0_pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         t0_ovf <= 1'b1;
         @(posedge clk);
         t0_ovf <= 1'b0;
      end
   endtask
   // count pulses below a quarter of the clock rate
   task automatic ext_pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk);
         ext_in <= 1'b1;
         repeat (4) @(posedge clk);
         ext_in <= 1'b0;
      end
   endtask
   task automatic set_pin(input int i, input logic v);
      @(posedge clk);
      drive[i] <= v;
   endtask
endmodule

// [testbench/tb.sv]
/* bench for pca_core: avalon register access, count sources, capture,
   compare, pwm, irq, watchdog. assumes pca_pins and the checker. */
`timescale 1ns/100ps
module tb;
   import pca_pkg::*;
   logic        clk;
   logic        rst_n;
   av_req_t     req;
   av_rsp_t     rsp;
   logic        t0_ovf;
   logic        ext_in;
   logic [4:0]  pin_in;
   logic [4:0]  pin_out;
   logic [4:0]  pin_oe;
   logic        irq;
   logic        wd_rst;
   logic        o0;
   int          n_fail;
   int          n_checks;
   logic [15:0] v;
   pca_core u_dut (.clk(clk), .rst_n(rst_n), .av_req(req), .av_rsp(rsp),
      .timer0_overflow(t0_ovf), .external_count_input(ext_in),
      .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
      .module_io_pin_oe(pin_oe), .irq(irq), .watchdog_reset(wd_rst));
   pca_pins u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .t0_ovf(t0_ovf), .ext_in(ext_in), .pin_in(pin_in));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask
   // one transfer, held until waitrequest is seen low
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [7:0] d, output logic [15:0] q);
      @(posedge clk);
      req.address <= a;
      req.read <= ~w;
      req.write <= w;
      req.writedata <= {~d, d, ~d, d}; // upper lanes must be ignored
      @(posedge clk);
      while (rsp.waitrequest !== 1'b0) @(posedge clk);
      q = {8'h00, rsp.readdata[7:0]};
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [15:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      bus(a, 1'b0, 8'h00, q);
   endtask
   task automatic wr16(input logic [7:0] lo, hi, input logic [15:0] d);
      wr(lo, d[7:0]);
      wr(hi, d[15:8]);
   endtask
   task automatic rd16(input logic [7:0] lo, hi, output logic [15:0] d);
      logic [15:0] q;
      rd(lo, d);
      rd(hi, q);
      d = {q[7:0], d[7:0]};
   endtask
   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      report_and_stop;
   end
   initial begin
      rst_n = 1'b0;
      req = '0;
      req.byteenable = 4'hF;
      n_fail = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CONTROL, v);
      chk("ctrl reset", v, 16'h0000);
      // lane 0 disabled: write ignored
      req.byteenable <= 4'h0;
      wr(OFS_MODE, 8'h06);
      req.byteenable <= 4'hF;
      rd(OFS_MODE, v);
      chk("be0 write", v, 16'h0000);
      // internal sources over about 122 cycles
      for (int s = 0; s < 2; s++) begin
         wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h0000);
         wr(OFS_MODE, {6'h00, s[0], 1'b0});
         wr(OFS_CONTROL, 8'h40);
         repeat (120) @(posedge clk);
         wr(OFS_CONTROL, 8'h00);
         rd16(OFS_COUNT_L, OFS_COUNT_H, v);
         chk("rate", 16'(s ? (v > 16'h3A && v < 16'h40)
            : (v > 16'h12 && v < 16'h17)), 16'h0001);
      end
      // timer 0 and external pin counts, run control
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h0000);
      wr(OFS_MODE, 8'h04);
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(5);
      wr(OFS_MODE, 8'h06);
      u_pins.ext_pulses(4);
      repeat (6) @(posedge clk);
      wr(OFS_CONTROL, 8'h00);
      u_pins.t0_pulses(3);
      rd16(OFS_COUNT_L, OFS_COUNT_H, v);
      chk("src count", v, 16'h0009);
      // idle stop
      wr(OFS_IDLE, 8'h01);
      wr(OFS_MODE, 8'h84);
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(3);
      wr(OFS_MODE, 8'h04);
      u_pins.t0_pulses(2);
      repeat (3) @(posedge clk);
      rd16(OFS_COUNT_L, OFS_COUNT_H, v);
      chk("idle", v, 16'h000B);
      wr(OFS_IDLE, 8'h00);
      // overflow flag, sticky, irq
      wr(OFS_CONTROL, 8'h00);
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'hFFFF);
      wr(OFS_MODE, 8'h05);
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(3);
      repeat (4) @(posedge clk);
      rd(OFS_CONTROL, v);
      chk("ovf flag", v, 16'h00C0);
      chk("ovf irq", {15'h0000, irq}, 16'h0001);
      wr(OFS_CONTROL, 8'h00);
      repeat (3) @(posedge clk);
      chk("irq clr", {15'h0000, irq}, 16'h0000);
      // capture: falling, rising, both on module 1
      for (int k = 1; k <= 3; k++) begin
         wr(OFS_MMODE + 8'h04, {2'b00, k[1:0], 4'h0});
         wr16(OFS_VAL_L + 8'h04, OFS_VAL_H + 8'h04, 16'h0000);
         for (int e = 0; e < 2; e++) begin
            wr(OFS_CONTROL, 8'h00);
            wr16(OFS_COUNT_L, OFS_COUNT_H, e ? 16'h5678 : 16'h1234);
            u_pins.set_pin(1, e[0]);
            repeat (8) @(posedge clk);
            rd(OFS_CONTROL, v);
            chk("cap flag", v, {14'h0000, k[e], 1'b0});
            rd16(OFS_VAL_L + 8'h04, OFS_VAL_H + 8'h04, v);
            chk("cap val", v, k[e] ? (e ? 16'h5678 : 16'h1234)
               : (e && k[0] ? 16'h1234 : 16'h0000));
         end
      end
      // compare: module 2 toggles with irq, module 0 without hit enable
      wr(OFS_MMODE, 8'h40);
      wr(OFS_MMODE + 8'h08, 8'h4D);
      wr16(OFS_VAL_L, OFS_VAL_H, 16'h0003);
      wr16(OFS_VAL_L + 8'h08, OFS_VAL_H + 8'h08, 16'h0003);
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h0000);
      wr(OFS_MODE, 8'h04);
      rd(OFS_MMODE + 8'h08, v);
      o0 = pin_out[2];
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(4);
      repeat (4) @(posedge clk);
      rd(OFS_CONTROL, v);
      chk("hit flag", v, 16'h0044);
      chk("toggle", {15'h0000, pin_out[2]}, {15'h0000, ~o0});
      chk("mod irq", {15'h0000, irq}, 16'h0001);
      wr(OFS_MMODE + 8'h08, 8'h4C);
      repeat (3) @(posedge clk);
      chk("irq mask", {15'h0000, irq}, 16'h0000);
      // pwm on modules 3 and 0, then reload at low byte wrap
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_MMODE, 8'h42);
      wr(OFS_MMODE + 8'h0C, 8'h42);
      wr16(OFS_VAL_L + 8'h0C, OFS_VAL_H + 8'h0C, 16'h4080);
      wr16(OFS_VAL_L, OFS_VAL_H, 16'h0010);
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h007F);
      repeat (4) @(posedge clk);
      chk("pwm", {11'h000, pin_out[3], 3'h0, pin_out[0]}, 16'h0001);
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h00FF);
      repeat (4) @(posedge clk);
      chk("pwm hi", {15'h0000, pin_out[3]}, 16'h0001);
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(1);
      repeat (4) @(posedge clk);
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_VAL_L + 8'h0C, v);
      chk("reload", v, 16'h0040);
      // watchdog on module 4, then module 4 as plain timer
      wr16(OFS_VAL_L + 8'h10, OFS_VAL_H + 8'h10, 16'h0102);
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h0100);
      wr(OFS_MODE, 8'h44);
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(1);
      repeat (4) @(posedge clk);
      chk("wd early", {15'h0000, wd_rst}, 16'h0000);
      u_pins.t0_pulses(1);
      repeat (4) @(posedge clk);
      chk("wd fire", {15'h0000, wd_rst}, 16'h0001);
      wr(OFS_MODE, 8'h04);
      wr(OFS_MMODE + 8'h10, 8'h48);
      wr16(OFS_COUNT_L, OFS_COUNT_H, 16'h0100);
      wr(OFS_CONTROL, 8'h40);
      u_pins.t0_pulses(2);
      repeat (4) @(posedge clk);
      rd(OFS_CONTROL, v);
      chk("mod4 hit", v, 16'h0050);
      chk("wd off", {15'h0000, wd_rst}, 16'h0000);
      rd(8'h34, v);
      chk("unmapped", v, 16'h0000);
      report_and_stop;
   end
endmodule
